/* File: board_test_pkg.sv */
// constants and carrier types for the board test pin access block
// assumes a 32-bit apb master and a single 250 MHz clock
package board_test_pkg;

  // register byte offsets
  localparam logic [7:0] PIN_SNAP_OFS  = 8'h00;
  localparam logic [7:0] PIN_LOAD_OFS  = 8'h04;
  localparam logic [7:0] MODE_STAT_OFS = 8'h08;

  // snapshot / load packet field positions
  localparam int B0_RESET   = 7;
  localparam int B0_ADDR2   = 6;
  localparam int B0_CS_HI   = 5;
  localparam int B0_CS_LO   = 4;
  localparam int B0_PWRVLD  = 3;
  localparam int B0_ALO_HI  = 2;
  localparam int B0_ALO_LO  = 1;
  localparam int B0_IRQ     = 0;
  localparam int B1_DATA_OE = 15;
  localparam int B1_MODE    = 14;
  localparam int B1_BUSPWR  = 13;
  localparam int B1_DMA_REQUEST_LINE   = 12;
  localparam int B1_IO_READY_LINE   = 11;
  localparam int B1_DMA_ACK_LINE   = 10;
  localparam int B1_RDSTB   = 9;
  localparam int B1_WRSTB   = 8;
  localparam int B2_LSB     = 16;
  localparam int B3_LSB     = 24;

  // mode status fields
  localparam int STAT_TEST_MODE = 0;
  localparam int STAT_PIN_CTL   = 1;
  localparam int STAT_STRAP     = 2;

  // reset values
  localparam logic [31:0] LOAD_RESET = 32'h0000_0000;
  localparam logic [31:0] SNAP_RESET = 32'h0000_0000;

  // sampled levels of the storage-side pins
  typedef struct packed {
    logic        drive_reset_line;
    logic        drive_addr_bit2;
    logic [1:0]  chip_select;
    logic        drive_power_valid;
    logic [1:0]  drive_addr_low;
    logic        drive_irq_line;
    logic        bus_power_drive_enable;
    logic        dma_request_line;
    logic        io_ready_line;
    logic        dma_ack_line;
    logic        read_strobe_line;
    logic        write_strobe_line;
    logic [15:0] drive_data_bus;
  } pins_in_t;

  // driven levels of the storage-side outputs
  typedef struct packed {
    logic        drive_reset_line;
    logic [1:0]  chip_select;
    logic        drive_power_valid;
    logic [1:0]  drive_addr_low;
    logic        dma_ack_line;
    logic        read_strobe_line;
    logic        write_strobe_line;
    logic [15:0] drive_data_bus;
    logic        data_oe;
  } pins_out_t;

  localparam pins_out_t PINS_OUT_RESET = '{
    drive_reset_line:  1'b0,
    chip_select:       2'h3,
    drive_power_valid: 1'b0,
    drive_addr_low:    2'h0,
    dma_ack_line:      1'b1,
    read_strobe_line:  1'b1,
    write_strobe_line: 1'b1,
    drive_data_bus:    16'h0000,
    data_oe:           1'b0
  };

endpackage

/* File: board_test_pin_access.sv */
// apb-reached pin snapshot and pin load logic for board interconnect test
// assumes pin levels are synchronous to pclk; normal_out comes from the
// regular storage interface logic and is overridden once a load happens
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps

// Functional notes
// - snapshot byte 0 carries control-line levels
// - pins readable any time in test mode
// - bytes 1..3 carry strobes and data
// - load byte 1 bit 7 drives data
// - snapshot byte 1 bit 6 shows mode
// - load enters test mode, sets pins
// - test mode left only by reset
module board_test_pin_access
  import board_test_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire pins_in_t    pins_in,
  input  wire pins_out_t   normal_out,
  output      pins_out_t   pins_out,
  output      logic        test_mode
);

  typedef struct packed {
    logic        test_mode;
    logic        pin_ctl;
    logic        strap_done;
    logic        strap_low;
    logic [31:0] load;
    logic [31:0] snap;
    pins_out_t   pins;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == PIN_SNAP_OFS) || (a == PIN_LOAD_OFS) ||
                 (a == MODE_STAT_OFS);
  endfunction

  function automatic pins_out_t from_load(input logic [31:0] v);
    pins_out_t p;
    p                   = PINS_OUT_RESET;
    p.drive_reset_line  = v[B0_RESET];
    p.chip_select       = v[B0_CS_HI:B0_CS_LO];
    p.drive_power_valid = v[B0_PWRVLD];
    p.drive_addr_low    = v[B0_ALO_HI:B0_ALO_LO];
    p.dma_ack_line      = v[B1_DMA_ACK_LINE];
    p.read_strobe_line  = v[B1_RDSTB];
    p.write_strobe_line = v[B1_WRSTB];
    p.drive_data_bus    = v[B3_LSB+7:B2_LSB];
    p.data_oe           = v[B1_DATA_OE];
    from_load = p;
  endfunction

  logic [31:0] snap_now;
  logic [31:0] stat_word;
  logic [31:0] load_mask;

  always_comb begin
    snap_now              = 32'h0000_0000;
    snap_now[B0_RESET]    = pins_in.drive_reset_line;
    snap_now[B0_ADDR2]    = pins_in.drive_addr_bit2;
    snap_now[B0_CS_HI:B0_CS_LO]   = pins_in.chip_select;
    snap_now[B0_PWRVLD]   = pins_in.drive_power_valid;
    snap_now[B0_ALO_HI:B0_ALO_LO] = pins_in.drive_addr_low;
    snap_now[B0_IRQ]      = pins_in.drive_irq_line;
    snap_now[B1_MODE]     = st.test_mode;
    // byte 1 inputs and data bytes
    snap_now[B1_BUSPWR]   = pins_in.bus_power_drive_enable;
    snap_now[B1_DMA_REQUEST_LINE]    = pins_in.dma_request_line;
    snap_now[B1_IO_READY_LINE]    = pins_in.io_ready_line;
    snap_now[B1_DMA_ACK_LINE]    = pins_in.dma_ack_line;
    snap_now[B1_RDSTB]    = pins_in.read_strobe_line;
    snap_now[B1_WRSTB]    = pins_in.write_strobe_line;
    snap_now[B3_LSB+7:B2_LSB] = pins_in.drive_data_bus;

    stat_word                 = 32'h0000_0000;
    stat_word[STAT_TEST_MODE] = st.test_mode;
    stat_word[STAT_PIN_CTL]   = st.pin_ctl;
    stat_word[STAT_STRAP]     = st.strap_low;

    // read-only positions are dropped from a load
    load_mask = 32'h0000_0000;
    load_mask[B0_RESET]   = 1'b1;
    load_mask[B0_CS_HI:B0_CS_LO]   = 2'h3;
    load_mask[B0_PWRVLD]  = 1'b1;
    load_mask[B0_ALO_HI:B0_ALO_LO] = 2'h3;
    load_mask[B1_DATA_OE] = 1'b1;
    load_mask[B1_DMA_ACK_LINE]   = 1'b1;
    load_mask[B1_RDSTB]   = 1'b1;
    load_mask[B1_WRSTB]   = 1'b1;
    load_mask[B3_LSB+7:B2_LSB] = 16'hFFFF;
  end

  always_comb begin
    next_st = st;
    // pins sampled every cycle, independent of loads
    next_st.snap  = snap_now;
    next_st.ready = 1'b0;
    next_st.err   = 1'b0;

    // strap caught on the first edge after reset release
    if (!st.strap_done) begin
      next_st.strap_done = 1'b1;
      next_st.strap_low  = ~pins_in.drive_reset_line;
      if (!pins_in.drive_reset_line) begin
        next_st.test_mode = 1'b1;
      end
    end

    // setup phase: answer is ready in the first access cycle
    if (psel && !penable) begin
      next_st.ready = 1'b1;
      next_st.err   = ~known_addr(paddr);
      case (paddr)
        PIN_SNAP_OFS:  next_st.rdata = st.snap;
        PIN_LOAD_OFS:  next_st.rdata = st.load;
        MODE_STAT_OFS: next_st.rdata = stat_word;
        default:       next_st.rdata = 32'h0000_0000;
      endcase
    end

    // load enters test mode and takes pin control
    if (psel && penable && st.ready && pwrite &&
        paddr == PIN_LOAD_OFS) begin
      next_st.load      = pwdata & load_mask;
      next_st.test_mode = 1'b1;
      next_st.pin_ctl   = 1'b1;
    end

    // test mode and pin control never clear here
    // outputs follow the last load under pin_ctl, normal_out before that
    // data_oe from the load packet high bit of byte 1
    if (next_st.pin_ctl) begin
      next_st.pins = from_load(next_st.load);
    end else begin
      next_st.pins = normal_out;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{
        test_mode:  1'b0,
        pin_ctl:    1'b0,
        strap_done: 1'b0,
        strap_low:  1'b0,
        load:       LOAD_RESET,
        snap:       SNAP_RESET,
        pins:       PINS_OUT_RESET,
        rdata:      32'h0000_0000,
        ready:      1'b0,
        err:        1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  assign prdata    = st.rdata;
  assign pready    = st.ready;
  assign pslverr   = st.err;
  assign pins_out  = st.pins;
  assign test_mode = st.test_mode;

endmodule

/* File: storage_side_model.sv */
// storage side stand-in for the pin bus
// echoes the data bus while the block drives it
`timescale 1ns/100ps
module storage_side_model
  import board_test_pkg::*;
(
  input  wire pins_out_t pins_out,
  input  wire pins_in_t  ext,
  output      pins_in_t  pins_in
);
  always_comb begin
    pins_in = ext;
    if (pins_out.data_oe)
      pins_in.drive_data_bus = pins_out.drive_data_bus;
  end
endmodule

/* File: board_test_chk.sv */
// assertions on the board test pin access ports
// bound onto every instance of the block
`timescale 1ns/100ps
module board_test_chk
  import board_test_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire pins_in_t    pins_in,
  input wire pins_out_t   normal_out,
  input wire pins_out_t   pins_out,
  input wire logic        test_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ld = psel && penable && pready && pwrite && paddr == 8'h04;
  wire rd = psel && penable && pready && !pwrite && paddr == 8'h00;
  ready_one_a: assert property (psel && !penable |=> pready)
    else $error("ready late");
  bad_addr_a: assert property (pready && paddr > 8'h08 |-> pslverr)
    else $error("no slave error");
  load_mode_a: assert property (ld |=> test_mode)
    else $error("load kept normal mode");
  mode_hold_a: assert property (test_mode |=> test_mode)
    else $error("test mode dropped");
  load_bus_a: assert property (ld |=>
    pins_out.data_oe == $past(pwdata[15]) &&
    pins_out.drive_data_bus == $past(pwdata[31:16]))
    else $error("data bus not loaded");
  snap_low_a: assert property (rd |->
    prdata[7:0] == $past(pins_in[29:22], 2)) else $error("byte 0 wrong");
  snap_high_a: assert property (rd |->
    {prdata[31:16], prdata[13:8]} ==
    $past({pins_in[15:0], pins_in[21:16]}, 2))
    else $error("bytes 1 to 3 wrong");
  strap_a: assert property (!$past(presetn) &&
    !pins_in.drive_reset_line |=> test_mode) else $error("strap ignored");
  cover property (ld);
  cover property (rd && test_mode);
  cover property (pready && pslverr);
endmodule

bind board_test_pin_access board_test_chk chk_u (.*);

/* File: board_test_pin_access_tb.sv */
// self-checking bench for the board test pin access block
// apb master tasks, storage side model, checker bound in
`timescale 1ns/100ps
module board_test_pin_access_tb import board_test_pkg::*; ;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, wd = 0, rnd = 32'h6C21ABF5;
  logic        pready, pslverr, test_mode, tm;
  pins_in_t    ext = '1, pins_in;
  pins_out_t   normal_out = PINS_OUT_RESET, pins_out;
  logic [32:0] expq[$];
  int          mismatches = 0, checks_done = 0, cyc = 0;

  board_test_pin_access dut_u (.*);
  storage_side_model side_u (.*);

  always #2 pclk = ~pclk;

  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [31:0] snap(input pins_in_t p, input logic m);
    snap = {p[15:0], 1'b0, m, p[21:16], p[29:22]};
  endfunction
  function pins_out_t ld_exp(input logic [31:0] w);
    ld_exp = '{w[7], w[5:4], w[3], w[2:1], w[10], w[9], w[8], w[31:16], w[15]};
  endfunction

  task complete_run();
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp(input string n, input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [32:0] e);
    @(posedge pclk);
    if (!w)
      expq.push_back(e);
    // pwrite stands in for the transport direction flag
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task do_reset(input logic strap);
    @(posedge pclk);
    presetn <= 1'b0;
    ext.drive_reset_line <= strap;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
  endtask

  // read results leave the queue in issue order
  always @(negedge pclk)
    if (pready === 1'b1 && pwrite === 1'b0) begin
      if (expq.size() == 0)
        cmp("extra read", 33'h0, 33'h1);
      else
        cmp("read", expq.pop_front(), {pslverr, prdata});
    end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    do_reset(1'b0);
    cmp("mode", 33'h1, 33'(test_mode));
    cmp("pins", 33'(normal_out), 33'(pins_out));
    xfer(1'b0, 8'h08, 32'h0, 33'h5);
    do_reset(1'b1);
    cmp("mode", 33'h0, 33'(test_mode));
    tm = 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      rnd = lfsr(rnd);
      ext <= pins_in_t'(rnd[29:0]);
      normal_out <= pins_out_t'(rnd[31:6]);
      if (i == 2 || i == 4) begin
        wd = lfsr(~rnd);
        xfer(1'b1, 8'h04, wd, 33'h0);
        tm = 1'b1;
      end
      repeat (3) @(posedge pclk);
      #1;
      cmp("pins", tm ? 33'(ld_exp(wd)) : 33'(normal_out), 33'(pins_out));
      cmp("mode", 33'(tm), 33'(test_mode));
      xfer(1'b0, 8'h00, 32'h0, {1'b0, snap(pins_in, tm)});
      if (tm) begin
        xfer(1'b0, 8'h04, 32'h0, {1'b0, wd & 32'hFFFF87BE});
        xfer(1'b0, 8'h08, 32'h0, 33'h3);
      end
    end
    xfer(1'b0, 8'h0C, 32'h0, {1'b1, 32'h0});
    repeat (2) @(posedge pclk);
    complete_run();
  end
endmodule
